/* File: design/lcd_cmd_cfg.svh */
`ifndef LCD_CMD_CFG_SVH
`define LCD_CMD_CFG_SVH
// fixed upper six bits of the 7-bit write address
`define ADDR_UPPER        6'h1c
// continuation flag position in a command byte
`define CMD_CONT_BIT      7
// mode-set field positions
`define MODE_EN_BIT       3
`define MODE_BIAS_BIT     2
// drive mode codes
`define DRIVE_STATIC      2'h1
`define DRIVE_MUX2        2'h2
`define DRIVE_MUX3        2'h3
`define DRIVE_MUX4        2'h0
// reset values of decoded state
`define RST_DRIVE         2'h0
`define RST_PTR           6'h00
`define RST_SUBADDR       3'h0
// last legal data pointer value
`define PTR_LAST          6'h27
// pointer steps per drive mode
`define STEP_STATIC       6'h08
`define STEP_MUX2         6'h04
`define STEP_MUX3         6'h03
`define STEP_MUX4         6'h02
`endif

/* File: design/lcd_cmd_pkg.sv */
package lcd_cmd_pkg;
  // bus phase of the receiver
  typedef enum logic [2:0] {IDLE_ST, ADDR_ST, CMD_ST, DATA_ST, IGNORE_ST} phase_type;
endpackage : lcd_cmd_pkg

/* File: design/lcd_cmd_port.sv */
// Contract
// - sda change with scl high is control
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - no limit on bytes per transfer
// - eight bits then acknowledge slot
// - ack holds sda low whole pulse
// - receive only, never answer reads
// - address lsb must equal strap level
// - mismatched address: no ack, no action
// - byte after address is a command, acked
// - bit 7 set means more commands
// - data goes to pointer, both advance
// - ack data only when subaddress matches
// - decode mode-set and load pointer
// - decode device, bank, blink select
// - drive mode and bias encodings
// - pointer field copied to data pointer
// - bank select ignored in mux3 and mux4
// - blink rate and alternate bank handling
`timescale 1ns/1ps
`include "lcd_cmd_cfg.svh"
module lcd_cmd_port
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // i2c pins
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  // straps
  input  wire logic       ADDR_LSB_STRAP,
  input  wire logic [2:0] SUBADDRESS_PINS,
  // decoded settings
  output logic            DISP_EN,
  output logic            BIAS_HALF,
  output logic [1:0]      DRIVE_MODE,
  output logic            IN_BANK,
  output logic            OUT_BANK,
  output logic            BLINK_ALT,
  output logic [1:0]      BLINK_RATE_FIELD,
  // display data toward the ram loader
  output logic            DATA_STB,
  output logic [7:0]      DATA_BYTE,
  output logic [5:0]      DATA_PTR,
  output logic [2:0]      SUBADDR_CNT
);
  import lcd_cmd_pkg::*;

  logic [2:0] scl_sync_reg;   // two sync stages plus history
  logic [2:0] sda_sync_reg;
  logic       strap_meta_reg; // strap and subaddress pins, first stage
  logic [2:0] sub_meta_reg;
  logic       strap_reg;
  logic [2:0] sub_reg;
  logic       scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  phase_type  phase_reg;
  logic [3:0] bit_cnt_reg;    // 0..7 data bits, 8 = ack slot
  logic [7:0] shift_reg;
  logic       ack_pend_reg;   // decision to ack current byte
  logic [5:0] ptr_reg;
  logic [2:0] sa_reg;
  logic [5:0] step;
  logic       byte_done;

  // pointer step per drive mode
  function automatic logic [5:0] ptr_step(input logic [1:0] m);
    unique case (m)
      `DRIVE_STATIC: ptr_step = `STEP_STATIC;
      `DRIVE_MUX2:   ptr_step = `STEP_MUX2;
      `DRIVE_MUX3:   ptr_step = `STEP_MUX3;
      `DRIVE_MUX4:   ptr_step = `STEP_MUX4;
    endcase
  endfunction : ptr_step

  // true when an alternate bank exists
  function automatic logic has_bank(input logic [1:0] m);
    has_bank = (m == `DRIVE_STATIC) || (m == `DRIVE_MUX2);
  endfunction : has_bank

  // pin synchronisers; stage 0 is read only by stage 1
  // strap pins ride along, since they are off-chip too
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_sync_reg   <= 3'h7; // idle bus, so no false edge after reset
      sda_sync_reg   <= 3'h7;
      strap_meta_reg <= 1'b0;
      sub_meta_reg   <= 3'h0;
      strap_reg      <= 1'b0;
      sub_reg        <= 3'h0;
    end
    else
    begin
      scl_sync_reg   <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg   <= {sda_sync_reg[1:0], SDA_I};
      strap_meta_reg <= ADDR_LSB_STRAP;
      sub_meta_reg   <= SUBADDRESS_PINS;
      strap_reg      <= strap_meta_reg;
      sub_reg        <= sub_meta_reg;
    end
  end

  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_s & scl_sync_reg[2];
  // sda moving while scl stays high is a bus condition
  assign start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
  assign stop_det  = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];
  assign byte_done = scl_rise && (bit_cnt_reg == 4'h7);
  assign step      = ptr_step(DRIVE_MODE);

  // bit counter and shifter; sampled on scl rise
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
    end
    else if (start_det || stop_det)
      bit_cnt_reg <= 4'h0;
    else if (scl_rise)
    begin
      // ack slot closes the byte
      if (bit_cnt_reg == 4'h8)
        bit_cnt_reg <= 4'h0;
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg   <= {shift_reg[6:0], sda_s};
      end
    end
  end

  // bus phase; no byte limit, ends only on stop or start
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      phase_reg <= IDLE_ST;
    else if (start_det)
      phase_reg <= ADDR_ST; // repeated start also lands here
    else if (stop_det)
      phase_reg <= IDLE_ST;
    else if (byte_done)
    begin
      unique case (phase_reg)
        ADDR_ST:
        begin
          // write to our address only; reads and others dropped
          if (shift_reg[6:0] == {`ADDR_UPPER, strap_reg} && !sda_s)
            phase_reg <= CMD_ST;
          else
            phase_reg <= IGNORE_ST;
        end
        CMD_ST:
          if (!shift_reg[`CMD_CONT_BIT - 1])
            phase_reg <= DATA_ST;
        IDLE_ST, DATA_ST, IGNORE_ST:
          phase_reg <= phase_reg;
      endcase
    end
  end

  // ack decision, made as the eighth bit is taken
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      ack_pend_reg <= 1'b0;
    else if (start_det || stop_det)
      ack_pend_reg <= 1'b0;
    else if (byte_done)
    begin
      unique case (phase_reg)
        ADDR_ST:   ack_pend_reg <= (shift_reg[6:0] == {`ADDR_UPPER, strap_reg})
                                   && !sda_s;
        CMD_ST:    ack_pend_reg <= 1'b1;
        DATA_ST:   ack_pend_reg <= (sa_reg == sub_reg);
        IDLE_ST, IGNORE_ST: ack_pend_reg <= 1'b0;
      endcase
    end
    else if (scl_fall && bit_cnt_reg == 4'h0)
      ack_pend_reg <= 1'b0; // released after ack pulse
  end

  // sda drive: low from fall before slot to fall after it
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      SDA_OE <= 1'b0;
    else if (start_det || stop_det)
      SDA_OE <= 1'b0;
    else if (scl_fall)
      SDA_OE <= ack_pend_reg && (bit_cnt_reg == 4'h8); // only output is ack
  end

  // open-drain: never drive high
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      SDA_O <= 1'b0;
    else
      SDA_O <= 1'b0;
  end

  // command decode of settings, taken when the byte completes
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DISP_EN          <= 1'b0;
      BIAS_HALF        <= 1'b0;
      DRIVE_MODE       <= `RST_DRIVE;
      IN_BANK          <= 1'b0;
      OUT_BANK         <= 1'b0;
      BLINK_ALT        <= 1'b0;
      BLINK_RATE_FIELD <= 2'h0;
    end
    else if (byte_done && phase_reg == CMD_ST)
    begin
      // mode-set, bit 4 unused
      if (shift_reg[5:4] == 2'h2)
      begin
        DISP_EN    <= shift_reg[`MODE_EN_BIT - 1];
        BIAS_HALF  <= shift_reg[`MODE_BIAS_BIT - 1];
        DRIVE_MODE <= {shift_reg[0], sda_s};
        // no alternate bank in mux3/4, so its blinking drops
        BLINK_ALT  <= BLINK_ALT & has_bank({shift_reg[0], sda_s});
      end
      // bank-select, only with an alternate bank
      else if (shift_reg[5:1] == 5'h1e && has_bank(DRIVE_MODE))
      begin
        IN_BANK  <= shift_reg[0];
        OUT_BANK <= sda_s;
      end
      // blink-select; alternate bank forced off in mux3/4
      else if (shift_reg[5:2] == 4'he)
      begin
        BLINK_ALT        <= shift_reg[1] & has_bank(DRIVE_MODE);
        BLINK_RATE_FIELD <= {shift_reg[0], sda_s};
      end
    end
  end

  // data pointer and subaddress counter
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ptr_reg <= `RST_PTR;
      sa_reg  <= `RST_SUBADDR;
    end
    else if (byte_done && phase_reg == CMD_ST)
    begin
      if (shift_reg[5] == 1'b0)
        ptr_reg <= {shift_reg[4:0], sda_s};
      else if (shift_reg[5:2] == 4'hc)
        sa_reg <= {shift_reg[1:0], sda_s};
    end
    else if (byte_done && phase_reg == DATA_ST)
    begin
      // advance even when storage is inhibited; overflow bumps subaddress
      if (7'(ptr_reg) + 7'(step) > 7'(`PTR_LAST))
      begin
        ptr_reg <= 6'(ptr_reg + step - (`PTR_LAST + 6'h01));
        sa_reg  <= sa_reg + 3'h1;
      end
      else
        ptr_reg <= 6'(ptr_reg + step);
    end
  end

  // data strobe with the location it belongs to
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DATA_STB    <= 1'b0;
      DATA_BYTE   <= 8'h00;
      DATA_PTR    <= `RST_PTR;
      SUBADDR_CNT <= `RST_SUBADDR;
    end
    else
    begin
      DATA_STB    <= byte_done && phase_reg == DATA_ST && sa_reg == sub_reg;
      SUBADDR_CNT <= sa_reg;
      if (byte_done && phase_reg == DATA_ST)
      begin
        DATA_BYTE <= {shift_reg[6:0], sda_s};
        DATA_PTR  <= ptr_reg;
      end
    end
  end
endmodule : lcd_cmd_port

/* File: bench/lcd_cmd_master.sv */
`timescale 1ns/1ps
module lcd_cmd_master
(
  // open-drain lines, released level is 1
  output logic      scl = 1'b1,
  output logic      sda_m = 1'b1,
  // resolved wire
  input  wire logic sda
);
  // start from idle, or restart
  task automatic start_cond();
    sda_m = 1'b1;
    #10 scl = 1'b1;
    #6 sda_m = 1'b0;
    #6 scl = 1'b0;
    #10;
  endtask : start_cond
  // stop, scl then stands high
  task automatic stop_cond();
    sda_m = 1'b0;
    #10 scl = 1'b1;
    #12 sda_m = 1'b1;
    #12;
  endtask : stop_cond
  // msb first, then a released ack slot; sda moves only with scl low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_m = (i == 0) ? 1'b1 : b[i-1];
      #10 scl = 1'b1;
      #6 ack = ~sda;
      #6 scl = 1'b0;
      #10;
    end
  endtask : put_byte
endmodule : lcd_cmd_master

/* File: bench/lcd_cmd_port_chk.sv */
`timescale 1ns/1ps
module lcd_cmd_port_chk
(
  // clock and reset
  input wire logic       MCLK,
  input wire logic       RST_N,
  // bus side
  input wire logic       SCL_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE,
  // settings and strobe
  input wire logic [1:0] DRIVE_MODE,
  input wire logic       IN_BANK,
  input wire logic       OUT_BANK,
  input wire logic       BLINK_ALT,
  input wire logic       DATA_STB
);
  import lcd_cmd_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // mux3 or mux4: no second bank exists
  wire low_mux = (DRIVE_MODE == 2'h3) || (DRIVE_MODE == 2'h0);
  // a stored byte is acked within 300 clocks
  sequence ack_soon;
    ##[1:300] SDA_OE;
  endsequence
  sequence one_pulse;
    DATA_STB ##1 !DATA_STB;
  endsequence
  drive_low_a: assert property (SDA_O == 1'b0) else $error("sda driven high");
  stb_pulse_a: assert property ($rose(DATA_STB) |-> one_pulse) else $error("long strobe");
  stb_acked_a: assert property (DATA_STB |-> ack_soon) else $error("stored, no ack");
  ack_rise_a: assert property ($rose(SDA_OE) |-> !SCL_I) else $error("ack rose, scl high");
  ack_hold_a: assert property (SDA_OE && SCL_I |=> SDA_OE) else $error("ack cut short");
  ack_fall_a: assert property ($fell(SDA_OE) |-> !SCL_I) else $error("ack fell, scl high");
  bank_hold_a: assert property (low_mux ##1 low_mux |-> $stable({IN_BANK, OUT_BANK}))
    else $error("bank moved in mux3 or mux4");
  alt_off_a: assert property (low_mux |-> !BLINK_ALT) else $error("alt blink in mux3/4");
endmodule : lcd_cmd_port_chk
bind lcd_cmd_port lcd_cmd_port_chk i_lcd_cmd_port_chk
(
  .MCLK(MCLK), .RST_N(RST_N), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .DRIVE_MODE(DRIVE_MODE), .IN_BANK(IN_BANK), .OUT_BANK(OUT_BANK),
  .BLINK_ALT(BLINK_ALT), .DATA_STB(DATA_STB)
);

/* File: bench/test_lcd_cmd_port.sv */
`timescale 1ns/1ps
`include "lcd_cmd_cfg.svh"
module test_lcd_cmd_port;
  import lcd_cmd_pkg::*;
  logic        mclk;        // 250 MHz
  logic        rst_n;       // async, active low
  logic        strap;       // address lsb strap
  logic [2:0]  pins;        // hardware subaddress
  wire         scl;
  wire         sda_m;       // master drive
  wire         sda_o;
  wire         sda_oe;
  wire         sda;         // resolved wire with pull-up
  wire  [8:0]  cfg;         // packed decoded settings
  wire         stb;
  wire  [7:0]  dbyte;
  wire  [5:0]  dptr;
  wire  [2:0]  sub_cnt;
  logic        ack;
  int          fail_count;
  int          n_compared;
  int          stb_n = 0;   // strobes seen
  logic [13:0] stb_val;     // last byte and pointer
  // command rows beside the settings they leave
  logic [7:0]  cmd_tab [8] = '{8'hd9, 8'hfb, 8'hf7, 8'hc7, 8'hf8, 8'hf5, 8'hce, 8'hcc};
  logic [8:0]  exp_tab [8] = '{9'h120, 9'h138, 9'h13f, 9'h0fb, 9'h0fb, 9'h0f9, 9'h1d9, 9'h199};
  // open drain: only a low can win
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  lcd_cmd_port i_lcd_cmd_port
  (
    .MCLK(mclk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .ADDR_LSB_STRAP(strap), .SUBADDRESS_PINS(pins), .DISP_EN(cfg[8]), .BIAS_HALF(cfg[7]),
    .DRIVE_MODE(cfg[6:5]), .IN_BANK(cfg[4]), .OUT_BANK(cfg[3]), .BLINK_ALT(cfg[2]),
    .BLINK_RATE_FIELD(cfg[1:0]), .DATA_STB(stb), .DATA_BYTE(dbyte), .DATA_PTR(dptr),
    .SUBADDR_CNT(sub_cnt)
  );
  lcd_cmd_master i_lcd_cmd_master (.scl(scl), .sda_m(sda_m), .sda(sda));
  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // log bytes handed to the ram loader
  always @(posedge mclk)
  begin
    if (stb === 1'b1)
    begin
      stb_n <= stb_n + 1;
      stb_val <= {dbyte, dptr};
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // one byte and its ack
  task automatic send(input logic [7:0] b, input logic want);
    i_lcd_cmd_master.put_byte(b, ack);
    check(ack, want);
  endtask : send
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    strap = 1'b0;
    pins = 3'h1;
    rst_n = 1'b0;
    repeat (16) @(posedge mclk);
    check({sda_oe, stb, cfg, sub_cnt}, 24'h0);
    $display("reset done");
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    i_lcd_cmd_master.start_cond();
    send({`ADDR_UPPER, strap, 1'b0}, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      send(cmd_tab[k], 1'b1);
      check(cfg, exp_tab[k]);
    end
    $display("table done");
    // pointer 38 in mux4, then one unmatched and one matched byte
    send(8'ha6, 1'b1);
    send(8'h60, 1'b1);
    send(8'h5a, 1'b0);
    send(8'h3c, 1'b1);
    i_lcd_cmd_master.stop_cond();
    check({stb_n[3:0], stb_val, sub_cnt}, {4'h1, 8'h3c, 6'h00, 3'h1});
    $display("data done");
    // wrong lsb, then a read after a restart
    i_lcd_cmd_master.start_cond();
    send({`ADDR_UPPER, 1'b1, 1'b0}, 1'b0);
    send(8'hc9, 1'b0);
    check(cfg, 9'h199);
    i_lcd_cmd_master.start_cond();
    send({`ADDR_UPPER, strap, 1'b1}, 1'b0);
    i_lcd_cmd_master.stop_cond();
    $display("refusal done");
    summarize();
  end
  // hang guard, the run needs about 5 us
  initial
  begin
    #60000;
    fail_count++;
    summarize();
  end
endmodule : test_lcd_cmd_port
